// [hw/cior_pkg.sv]
// Package for the core IO control register bank: offsets, fields, reset values, structs
`default_nettype none
package cior_pkg;
  // ==========================================
  // Register offsets in IO space
  localparam logic [2:0] ADDR_ARITH_STATUS_FLAGS = 3'h0;
  localparam logic [2:0] ADDR_UNIT_ENABLE = 3'h1;
  localparam logic [2:0] ADDR_STACK_POINTER = 3'h2;
  localparam logic [2:0] ADDR_CLOCK_MODE = 3'h3;
  localparam logic [2:0] ADDR_INTERRUPT_ENABLE = 3'h4;
  localparam logic [2:0] ADDR_INTERRUPT_REQUEST = 3'h5;
  localparam logic [2:0] ADDR_TIMER_MODE = 3'h6;

  // ==========================================
  // Reset values and fixed bits
  localparam logic [3:0] FLAG_RSVD_ONES = 4'hF;
  localparam logic [1:0] UNIT_ENABLE_RESET = 2'h1;
  localparam logic [7:0] CLOCK_MODE_RESET = 8'hF6;
  localparam logic [7:0] TIMER_MODE_RESET = 8'h00;
  localparam logic [7:0] STACK_POINTER_RESET = 8'h00;
  localparam logic [3:0] INT_RESET = 4'h0;

  // ==========================================
  // Timing and field positions
  // Edges from a pin synchroniser are held back until all three stages have seen the pin
  localparam logic [1:0] SYNC_FILL_DONE = 2'h3;
  // Lowest timer counter bit that can raise the timer event
  localparam int TIMER_TAP_LSB = 8;

  // ==========================================
  // Interrupt source bit positions
  localparam int IRQ_PORT_A_PIN0 = 0;
  localparam int IRQ_PORT_B_PIN0 = 1;
  localparam int IRQ_TIMER = 2;
  localparam int IRQ_CONVERTER = 3;

  // ==========================================
  // Clock source selections
  typedef enum logic [2:0] {
    CIOR_SRC_NONE = 3'h0,
    CIOR_SRC_FAST_DIV1 = 3'h1,
    CIOR_SRC_FAST_DIV2 = 3'h2,
    CIOR_SRC_FAST_DIV4 = 3'h3,
    CIOR_SRC_EXT_DIV1 = 3'h4,
    CIOR_SRC_EXT_DIV2 = 3'h5,
    CIOR_SRC_SLOW_DIV1 = 3'h6,
    CIOR_SRC_OTHER = 3'h7
  } cior_src_t;

  // Flags update from the execution unit
  typedef struct packed {
    logic we_ov;
    logic ov;
    logic we_hc;
    logic hc;
    logic we_c;
    logic c;
    logic we_z;
    logic z;
  } cior_alu_flags_t;

  // IO-space access from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } cior_io_req_t;

  // Decoded clock-mode controls
  typedef struct packed {
    logic [2:0] sys_clk_sel;
    logic clk_type1;
    logic sys_clk_reserved;
    logic [3:0] sys_div_log2;
    logic sys_src_fast;
    logic sys_src_ext;
    logic sys_src_slow;
    logic fast_internal_rc_en;
    logic slow_internal_rc_en;
    logic watchdog_en;
    logic external_reset_input_sel;
  } cior_clk_ctrl_t;
endpackage : cior_pkg
`default_nettype wire

// [hw/cior_event_sync.sv]
// Three-stage synchroniser with rising/falling edge detection for one pin
`default_nettype none
module cior_event_sync
  import cior_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  // ==========================================
  // State
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic [1:0] fill;
  } cior_sync_state_t;

  cior_sync_state_t st;
  cior_sync_state_t next_st;
  logic primed;
  logic agree;

  assign primed = (st.fill == SYNC_FILL_DONE);
  // A change counts once the second and third stages agree on the new value
  assign agree = (st.s2 == st.s3);

  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // Level follows the chain until it is full, so a pin idling high gives no false edge after reset
    if (!primed) begin
      next_st.fill = 2'(st.fill + 2'h1);
      next_st.lvl = st.s2;
    end else if (agree) begin
      next_st.lvl = st.s3;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // One-cycle pulses; a single-cycle glitch never makes the two stages agree
  assign level = st.lvl;
  assign rise = primed & agree & st.s3 & ~st.lvl;
  assign fall = primed & agree & ~st.s3 & st.lvl;
endmodule : cior_event_sync
`default_nettype wire

// [hw/cior_regs.sv]
// Core IO control register bank: status flags, unit enables, stack pointer, clock, interrupts, timer mode
// How it works
// RULE1 - Bits 7 to 4 of the arithmetic status register always read as one.
// RULE2 - Bit 3 holds the signed overflow flag, set when a signed operation overflows.
// RULE3 - Bit 2 holds the half carry flag from the low nibble carry or borrow.
// RULE4 - Bit 1 holds the carry flag, set on carry or borrow and also written by shifts through carry.
// RULE5 - Bit 0 holds the zero flag, set for a zero result and cleared otherwise.
// RULE6 - The unit enable register has unit zero enabled and unit one disabled after reset, upper bits zero.
// RULE7 - The stack pointer is read and written at full width; software keeps bit 0 clear.
// RULE8 - With clock type 0 the system clock field picks fast/4, fast/2, -, ext/4, ext/2, ext, slow/4, slow.
// RULE9 - With clock type 1 the field picks fast/16, fast/8, -, fast/32, fast/64, ext/8, and reserved codes.
// RULE10 - Clock mode bits 4 and 2 enable the fast and slow RC oscillators and reset to one.
// RULE11 - Clock mode bit 1 enables the watchdog and resets to one.
// RULE12 - Clock mode bit 0 makes the shared pin a general IO (0) or the external reset input (1).
// RULE13 - Interrupt enable bits 3 to 0 gate converter, timer, port B pin 0 and port A pin 0 requests.
// RULE14 - Each request bit is set by its event and stays set until software clears it.
// RULE15 - Timer mode bits 7 to 5 pick the timer clock source, reset 000 meaning disabled.
// RULE16 - Timer mode bits 4 to 3 pick a timer prescale of 1, 4, 16 or 64.
// RULE17 - Timer mode bits 2 to 0 pick counter bit 8 to 15 whose rising edge raises the timer event.
`default_nettype none
module cior_regs
  import cior_pkg::*;
#(
  parameter int TIMER_WIDTH = 16
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire cior_io_req_t io_req,
  output logic [7:0] io_rdata,
  input wire cior_alu_flags_t alu_flags,
  input wire logic [TIMER_WIDTH-1:0] timer_count,
  input wire logic converter_done,
  input wire logic port_a_pin0,
  input wire logic port_b_pin0,
  output logic [3:0] arith_flags,
  output logic [1:0] unit_enable,
  output logic [7:0] stack_pointer,
  output cior_clk_ctrl_t clk_ctrl,
  output logic [2:0] timer_src_sel,
  output logic [6:0] timer_prescale,
  output logic [3:0] interrupt_pending,
  output logic interrupt_any
);
  // ==========================================
  // Parameter check
  if (TIMER_WIDTH != 16) begin : g_bad_width
    $error("cior_regs: TIMER_WIDTH must be 16");
  end

  // ==========================================
  // State
  typedef struct packed {
    logic [3:0] flags;
    logic [1:0] unit_en;
    logic [7:0] sp;
    logic [7:0] clk_mode;
    logic [3:0] int_en;
    logic [3:0] int_req;
    logic [7:0] tmr_mode;
    logic tap_q;
    logic [7:0] rdata;
  } cior_state_t;

  cior_state_t st;
  cior_state_t next_st;

  logic pa_rise;
  logic pa_fall;
  logic pb_rise;
  logic pb_fall;
  logic tap_now;
  logic timer_event;
  logic [3:0] events;
  logic wr_hit;

  // ==========================================
  // Pin synchronisers
  cior_event_sync u_sync_pa (
    .mclk(mclk),
    .arst_n(arst_n),
    .pin(port_a_pin0),
    .level(),
    .rise(pa_rise),
    .fall(pa_fall)
  );

  cior_event_sync u_sync_pb (
    .mclk(mclk),
    .arst_n(arst_n),
    .pin(port_b_pin0),
    .level(),
    .rise(pb_rise),
    .fall(pb_fall)
  );

  // ==========================================
  // Timer event
  // RULE17 selected counter bit
  assign tap_now = timer_count[TIMER_TAP_LSB + st.tmr_mode[2:0]];
  // Edge, not level, so a bit that stays high asks only once
  assign timer_event = tap_now & ~st.tap_q;

  // Both pin edges trigger; edge selection lives outside this bank
  always_comb begin
    events = '0;
    events[IRQ_PORT_A_PIN0] = pa_rise | pa_fall;
    events[IRQ_PORT_B_PIN0] = pb_rise | pb_fall;
    events[IRQ_TIMER] = timer_event;
    events[IRQ_CONVERTER] = converter_done;
  end

  assign wr_hit = io_req.wr;

  // ==========================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.tap_q = tap_now;
    // Software write first; hardware updates below take precedence
    if (wr_hit) begin
      unique case (io_req.addr)
        ADDR_ARITH_STATUS_FLAGS: next_st.flags = io_req.wdata[3:0];
        // RULE6 upper bits kept zero
        ADDR_UNIT_ENABLE: next_st.unit_en = io_req.wdata[1:0];
        // RULE7 full width write
        ADDR_STACK_POINTER: next_st.sp = io_req.wdata;
        ADDR_CLOCK_MODE: next_st.clk_mode = io_req.wdata;
        ADDR_INTERRUPT_ENABLE: next_st.int_en = io_req.wdata[3:0];
        ADDR_INTERRUPT_REQUEST: next_st.int_req = io_req.wdata[3:0];
        ADDR_TIMER_MODE: next_st.tmr_mode = io_req.wdata;
        default: next_st.flags = st.flags;
      endcase
    end
    // RULE2 overflow flag update
    if (alu_flags.we_ov) begin
      next_st.flags[3] = alu_flags.ov;
    end
    // RULE3 half carry update
    if (alu_flags.we_hc) begin
      next_st.flags[2] = alu_flags.hc;
    end
    // RULE4 carry and shift update
    if (alu_flags.we_c) begin
      next_st.flags[1] = alu_flags.c;
    end
    // RULE5 zero flag update
    if (alu_flags.we_z) begin
      next_st.flags[0] = alu_flags.z;
    end
    // RULE14 sticky set wins over clear
    next_st.int_req = next_st.int_req | events;
    // Read data registered for the core
    next_st.rdata = '0;
    if (io_req.rd) begin
      unique case (io_req.addr)
        // RULE1 reserved bits read one
        ADDR_ARITH_STATUS_FLAGS: next_st.rdata = {FLAG_RSVD_ONES, st.flags};
        ADDR_UNIT_ENABLE: next_st.rdata = {6'h00, st.unit_en};
        ADDR_STACK_POINTER: next_st.rdata = st.sp;
        ADDR_CLOCK_MODE: next_st.rdata = st.clk_mode;
        ADDR_INTERRUPT_ENABLE: next_st.rdata = {4'h0, st.int_en};
        ADDR_INTERRUPT_REQUEST: next_st.rdata = {4'h0, st.int_req};
        ADDR_TIMER_MODE: next_st.rdata = st.tmr_mode;
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st.flags <= '0;
      st.unit_en <= UNIT_ENABLE_RESET;
      st.sp <= STACK_POINTER_RESET;
      st.clk_mode <= CLOCK_MODE_RESET;
      st.int_en <= INT_RESET;
      st.int_req <= INT_RESET;
      st.tmr_mode <= TIMER_MODE_RESET;
      st.tap_q <= 1'b0;
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // Clock mode decode
  always_comb begin
    clk_ctrl = '0;
    clk_ctrl.sys_clk_sel = st.clk_mode[7:5];
    clk_ctrl.clk_type1 = st.clk_mode[3];
    // RULE10 oscillator enables
    clk_ctrl.fast_internal_rc_en = st.clk_mode[4];
    clk_ctrl.slow_internal_rc_en = st.clk_mode[2];
    // RULE11 watchdog enable
    clk_ctrl.watchdog_en = st.clk_mode[1];
    // RULE12 shared pin role
    clk_ctrl.external_reset_input_sel = st.clk_mode[0];
    if (!st.clk_mode[3]) begin
      // RULE8 type 0 selections
      unique case (st.clk_mode[7:5])
        3'h0: begin clk_ctrl.sys_src_fast = 1'b1; clk_ctrl.sys_div_log2 = 4'h2; end
        3'h1: begin clk_ctrl.sys_src_fast = 1'b1; clk_ctrl.sys_div_log2 = 4'h1; end
        3'h2: clk_ctrl.sys_clk_reserved = 1'b1;
        3'h3: begin clk_ctrl.sys_src_ext = 1'b1; clk_ctrl.sys_div_log2 = 4'h2; end
        3'h4: begin clk_ctrl.sys_src_ext = 1'b1; clk_ctrl.sys_div_log2 = 4'h1; end
        3'h5: clk_ctrl.sys_src_ext = 1'b1;
        3'h6: begin clk_ctrl.sys_src_slow = 1'b1; clk_ctrl.sys_div_log2 = 4'h2; end
        3'h7: clk_ctrl.sys_src_slow = 1'b1;
      endcase
    end else begin
      // RULE9 type 1 selections
      unique case (st.clk_mode[7:5])
        3'h0: begin clk_ctrl.sys_src_fast = 1'b1; clk_ctrl.sys_div_log2 = 4'h4; end
        3'h1: begin clk_ctrl.sys_src_fast = 1'b1; clk_ctrl.sys_div_log2 = 4'h3; end
        3'h3: begin clk_ctrl.sys_src_fast = 1'b1; clk_ctrl.sys_div_log2 = 4'h5; end
        3'h4: begin clk_ctrl.sys_src_fast = 1'b1; clk_ctrl.sys_div_log2 = 4'h6; end
        3'h5: begin clk_ctrl.sys_src_ext = 1'b1; clk_ctrl.sys_div_log2 = 4'h3; end
        default: clk_ctrl.sys_clk_reserved = 1'b1;
      endcase
    end
  end

  // ==========================================
  // Timer mode decode
  // RULE15 clock source field
  assign timer_src_sel = st.tmr_mode[7:5];
  // RULE16 prescale as divisor minus one
  always_comb begin
    unique case (st.tmr_mode[4:3])
      2'h0: timer_prescale = 7'h00;
      2'h1: timer_prescale = 7'h03;
      2'h2: timer_prescale = 7'h0F;
      2'h3: timer_prescale = 7'h3F;
    endcase
  end

  // ==========================================
  // Outputs
  assign io_rdata = st.rdata;
  assign arith_flags = st.flags;
  assign unit_enable = st.unit_en;
  assign stack_pointer = st.sp;
  // RULE13 enable gating
  assign interrupt_pending = st.int_req & st.int_en;
  assign interrupt_any = |interrupt_pending;

  // ==========================================
  // Checks
  a_flag_reserved_ones: assert property (@(posedge mclk) disable iff (!arst_n) // RULE1
    $past(io_req.rd) && $past(io_req.addr) == ADDR_ARITH_STATUS_FLAGS |-> io_rdata[7:4] == 4'hF)
    else $error("reserved flag bits not read as one");
  a_overflow_update: assert property (@(posedge mclk) disable iff (!arst_n) // RULE2
    alu_flags.we_ov |=> arith_flags[3] == $past(alu_flags.ov))
    else $error("overflow flag not updated");
  a_half_carry_update: assert property (@(posedge mclk) disable iff (!arst_n) // RULE3
    alu_flags.we_hc |=> arith_flags[2] == $past(alu_flags.hc))
    else $error("half carry flag not updated");
  a_carry_update: assert property (@(posedge mclk) disable iff (!arst_n) // RULE4
    alu_flags.we_c |=> arith_flags[1] == $past(alu_flags.c))
    else $error("carry flag not updated");
  a_zero_update: assert property (@(posedge mclk) disable iff (!arst_n) // RULE5
    alu_flags.we_z |=> arith_flags[0] == $past(alu_flags.z))
    else $error("zero flag not updated");
  a_sp_full_write: assert property (@(posedge mclk) disable iff (!arst_n) // RULE7
    io_req.wr && io_req.addr == ADDR_STACK_POINTER |=> stack_pointer == $past(io_req.wdata))
    else $error("stack pointer write lost");
  a_request_sticky: assert property (@(posedge mclk) disable iff (!arst_n) // RULE14
    st.int_req[IRQ_TIMER] && !(io_req.wr && io_req.addr == ADDR_INTERRUPT_REQUEST) |=> st.int_req[IRQ_TIMER])
    else $error("timer request dropped without clear");
  a_timer_event_set: assert property (@(posedge mclk) disable iff (!arst_n) // RULE17
    $rose(tap_now) |=> st.int_req[IRQ_TIMER])
    else $error("timer tap edge did not raise request");
  a_pending_gated: assert property (@(posedge mclk) disable iff (!arst_n) // RULE13
    io_req.wr && io_req.addr == ADDR_INTERRUPT_ENABLE && !io_req.wdata[IRQ_CONVERTER]
    |=> !interrupt_pending[IRQ_CONVERTER])
    else $error("converter request not gated");
  a_unit_reserved_zero: assert property (@(posedge mclk) disable iff (!arst_n) // RULE6
    io_req.rd && io_req.addr == ADDR_UNIT_ENABLE |=> io_rdata[7:2] == 6'h00)
    else $error("unit enable reserved bits not zero");
  a_osc_enable_write: assert property (@(posedge mclk) disable iff (!arst_n) // RULE10
    io_req.wr && io_req.addr == ADDR_CLOCK_MODE |=> clk_ctrl.fast_internal_rc_en == $past(io_req.wdata[4])
    && clk_ctrl.slow_internal_rc_en == $past(io_req.wdata[2]))
    else $error("oscillator enables not taken from clock mode");
  a_watchdog_write: assert property (@(posedge mclk) disable iff (!arst_n) // RULE11
    io_req.wr && io_req.addr == ADDR_CLOCK_MODE |=> clk_ctrl.watchdog_en == $past(io_req.wdata[1]))
    else $error("watchdog enable not taken from clock mode");
  a_pin_role_write: assert property (@(posedge mclk) disable iff (!arst_n) // RULE12
    io_req.wr && io_req.addr == ADDR_CLOCK_MODE |=> clk_ctrl.external_reset_input_sel == $past(io_req.wdata[0]))
    else $error("shared pin role not taken from clock mode");
  a_type0_slow_clock: assert property (@(posedge mclk) disable iff (!arst_n) // RULE8
    !clk_ctrl.clk_type1 && clk_ctrl.sys_clk_sel == 3'h7
    |-> clk_ctrl.sys_src_slow && clk_ctrl.sys_div_log2 == 4'h0 && !clk_ctrl.sys_clk_reserved)
    else $error("type 0 slow clock selection wrong");
  a_type1_reserved_codes: assert property (@(posedge mclk) disable iff (!arst_n) // RULE9
    clk_ctrl.clk_type1 && clk_ctrl.sys_clk_sel[2:1] == 2'h3 |-> clk_ctrl.sys_clk_reserved)
    else $error("type 1 reserved code not flagged");
  a_timer_src_write: assert property (@(posedge mclk) disable iff (!arst_n) // RULE15
    io_req.wr && io_req.addr == ADDR_TIMER_MODE |=> timer_src_sel == $past(io_req.wdata[7:5]))
    else $error("timer source not taken from timer mode");
  a_prescale_largest: assert property (@(posedge mclk) disable iff (!arst_n) // RULE16
    st.tmr_mode[4:3] == 2'h3 |-> timer_prescale == 7'h3F)
    else $error("largest timer prescale wrong");
  a_event_beats_clear: assert property (@(posedge mclk) disable iff (!arst_n) // RULE14
    converter_done && io_req.wr && io_req.addr == ADDR_INTERRUPT_REQUEST |=> st.int_req[IRQ_CONVERTER])
    else $error("converter event lost to a same-cycle clear");
endmodule : cior_regs
`default_nettype wire

// [verification/cior_regs_tb.sv]
// Self-checking testbench for the core IO control register bank
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module cior_regs_tb import cior_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  cior_io_req_t io_req = '0;
  cior_alu_flags_t alu_flags = '0;
  logic [15:0] timer_count = 16'h0000;
  logic converter_done = 1'b0;
  logic port_a_pin0 = 1'b0;
  logic port_b_pin0 = 1'b0;
  logic [7:0] io_rdata;
  logic [3:0] arith_flags;
  logic [1:0] unit_enable;
  logic [7:0] stack_pointer;
  cior_clk_ctrl_t clk_ctrl;
  logic [2:0] timer_src_sel;
  logic [6:0] timer_prescale;
  logic [3:0] interrupt_pending;
  logic interrupt_any;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  // Per entry: clock mode byte, then {reserved, fast, ext, slow, div_log2}
  logic [15:0] clk_tbl [16] = '{16'h1642, 16'h3641, 16'h7622, 16'h9621, 16'hB620, 16'hD612, 16'hF610,
    16'h56FF, 16'h1E44, 16'h3E43, 16'h7E45, 16'h9E46, 16'hBE23, 16'h5EFF, 16'hDEFF, 16'hFEFF};

  cior_regs #(.TIMER_WIDTH(16)) dut_u (.mclk(mclk), .arst_n(arst_n), .io_req(io_req), .io_rdata(io_rdata),
    .alu_flags(alu_flags), .timer_count(timer_count), .converter_done(converter_done),
    .port_a_pin0(port_a_pin0), .port_b_pin0(port_b_pin0), .arith_flags(arith_flags),
    .unit_enable(unit_enable), .stack_pointer(stack_pointer), .clk_ctrl(clk_ctrl),
    .timer_src_sel(timer_src_sel), .timer_prescale(timer_prescale),
    .interrupt_pending(interrupt_pending), .interrupt_any(interrupt_any));

  // ==========================================
  // Clock, timeout and verdict
  always #25 mclk = ~mclk;

  // A hang in any wait ends the run as a failure
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // ==========================================
  // IO-space accesses, entered and left at a falling edge
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    io_req.wr = 1'b1;
    io_req.addr = a;
    io_req.wdata = d;
    @(negedge mclk);
    io_req.wr = 1'b0;
    @(negedge mclk);
  endtask : wr_reg

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input string nm);
    io_req.rd = 1'b1;
    io_req.addr = a;
    @(negedge mclk);
    `CHK(nm, e, io_rdata)
    io_req.rd = 1'b0;
    @(negedge mclk);
  endtask : rd_chk

  // ==========================================
  // Scenarios
  task automatic t_reset();
    rd_chk(ADDR_ARITH_STATUS_FLAGS, 8'hF0, "flags");
    rd_chk(ADDR_UNIT_ENABLE, 8'h01, "unit_en");
    rd_chk(ADDR_STACK_POINTER, 8'h00, "sp");
    rd_chk(ADDR_CLOCK_MODE, 8'hF6, "clkmode");
    rd_chk(ADDR_INTERRUPT_ENABLE, 8'h00, "inten");
    rd_chk(ADDR_INTERRUPT_REQUEST, 8'h00, "intreq");
    rd_chk(ADDR_TIMER_MODE, 8'h00, "tmode");
    rd_chk(3'h7, 8'h00, "unmapped");
    `CHK("clk_en", 4'hE, {clk_ctrl.fast_internal_rc_en, clk_ctrl.slow_internal_rc_en,
      clk_ctrl.watchdog_en, clk_ctrl.external_reset_input_sel})
    `CHK("wdog_rst", 1'b1, clk_ctrl.watchdog_en)
    `CHK("unit_out", 2'h1, unit_enable)
  endtask : t_reset

  task automatic t_flags();
    alu_flags = 8'hFF;
    @(negedge mclk);
    alu_flags = 8'h08;
    @(negedge mclk);
    alu_flags = '0;
    `CHK("flags_out", 4'hD, arith_flags)
    rd_chk(ADDR_ARITH_STATUS_FLAGS, 8'hFD, "flags_rd");
    alu_flags = 8'h2E;
    @(negedge mclk);
    alu_flags = 8'hB0;
    @(negedge mclk);
    alu_flags = '0;
    `CHK("flags_hc", 4'h6, arith_flags)
    wr_reg(ADDR_ARITH_STATUS_FLAGS, 8'h0A);
    rd_chk(ADDR_ARITH_STATUS_FLAGS, 8'hFA, "flags_wr");
  endtask : t_flags

  task automatic t_regs();
    logic [15:0] t;
    wr_reg(ADDR_STACK_POINTER, 8'hFE);
    rd_chk(ADDR_STACK_POINTER, 8'hFE, "sp_full");
    `CHK("sp_out", 8'hFE, stack_pointer)
    wr_reg(ADDR_UNIT_ENABLE, 8'hFE);
    rd_chk(ADDR_UNIT_ENABLE, 8'h02, "unit_rsvd");
    `CHK("unit_out2", 2'h2, unit_enable)
    for (int i = 0; i < 16; i++) begin
      t = clk_tbl[i];
      wr_reg(ADDR_CLOCK_MODE, t[15:8]);
      `CHK("clk_sel", {t[15:13], t[11]}, {clk_ctrl.sys_clk_sel, clk_ctrl.clk_type1})
      if (t[7]) begin
        `CHK("clk_rsvd", 1'b1, clk_ctrl.sys_clk_reserved)
      end else begin
        `CHK("clk_dec", t[7:0], {clk_ctrl.sys_clk_reserved, clk_ctrl.sys_src_fast, clk_ctrl.sys_src_ext,
          clk_ctrl.sys_src_slow, clk_ctrl.sys_div_log2})
      end
    end
    wr_reg(ADDR_CLOCK_MODE, 8'h01);
    `CHK("clk_en2", 4'h1, {clk_ctrl.fast_internal_rc_en, clk_ctrl.slow_internal_rc_en,
      clk_ctrl.watchdog_en, clk_ctrl.external_reset_input_sel})
    for (int i = 0; i < 8; i++) begin
      wr_reg(ADDR_TIMER_MODE, {i[2:0], i[1:0], i[2:0]});
      `CHK("tsrc", i[2:0], timer_src_sel)
      `CHK("tpre", 7'((1 << (2 * i[1:0])) - 1), timer_prescale)
      rd_chk(ADDR_TIMER_MODE, {i[2:0], i[1:0], i[2:0]}, "tmode_rd");
    end
  endtask : t_regs

  task automatic t_irq();
    wr_reg(ADDR_INTERRUPT_ENABLE, 8'hFF);
    rd_chk(ADDR_INTERRUPT_ENABLE, 8'h0F, "inten_rd");
    wr_reg(ADDR_TIMER_MODE, 8'h03);
    timer_count = 16'h0400;
    repeat (3) @(negedge mclk);
    rd_chk(ADDR_INTERRUPT_REQUEST, 8'h00, "tmr_other");
    timer_count = 16'h0800;
    repeat (2) @(negedge mclk);
    rd_chk(ADDR_INTERRUPT_REQUEST, 8'h04, "tmr_sel");
    port_a_pin0 = 1'b1;
    repeat (6) @(negedge mclk);
    `CHK("pend_a", 4'h5, interrupt_pending)
    port_b_pin0 = 1'b1;
    converter_done = 1'b1;
    @(negedge mclk);
    converter_done = 1'b0;
    repeat (6) @(negedge mclk);
    rd_chk(ADDR_INTERRUPT_REQUEST, 8'h0F, "intreq_all");
    wr_reg(ADDR_INTERRUPT_ENABLE, 8'h00);
    `CHK("pend_mask", 5'h00, {interrupt_any, interrupt_pending})
    wr_reg(ADDR_INTERRUPT_ENABLE, 8'h08);
    `CHK("pend_conv", 5'h18, {interrupt_any, interrupt_pending})
    // Event in the same cycle as the clear must win
    converter_done = 1'b1;
    io_req.wr = 1'b1;
    io_req.addr = ADDR_INTERRUPT_REQUEST;
    io_req.wdata = 8'h00;
    @(negedge mclk);
    converter_done = 1'b0;
    io_req.wr = 1'b0;
    @(negedge mclk);
    rd_chk(ADDR_INTERRUPT_REQUEST, 8'h08, "ev_beats_clr");
    wr_reg(ADDR_INTERRUPT_REQUEST, 8'h00);
    rd_chk(ADDR_INTERRUPT_REQUEST, 8'h00, "intreq_clr");
  endtask : t_irq

  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(negedge mclk);
    arst_n = 1'b1;
    @(negedge mclk);
    t_reset();
    t_flags();
    t_regs();
    t_irq();
    stop_test();
  end
endmodule : cior_regs_tb
`default_nettype wire
